// [ssadc_pkg.sv]
// shared constants and types for the simultaneous-sampling adc serial link
package ssadc_pkg;
	localparam int NUM_CH = 8;
	localparam int RES_W = 16;
	localparam int CODE_W = 3;
	localparam int CFG_W = NUM_CH * CODE_W;
	localparam int CH_ID_W = 3;
	localparam int REC_W = 24;
	localparam int STREAM_W = NUM_CH * REC_W;
	localparam int CNT_W = 8;
	localparam int CFGCNT_W = 5;
	localparam logic [CFGCNT_W-1:0] CFG_BITS = 5'h18;
	localparam logic [CFGCNT_W-1:0] CFG_STEP_CMOS = 5'h01;
	localparam logic [CFGCNT_W-1:0] CFG_STEP_LVDS = 5'h02;
	localparam logic [CFG_W-1:0] CFG_RESET = 24'hffffff;
	localparam logic [CODE_W-1:0] CODE_OFF = 3'h0;
	localparam logic [1:0] REC_PAD = 2'h0;
	// conversion timing on the reference clock
	localparam int REF_PERIOD_NS = 25;
	localparam int CONV_TIME_NS = 3000;
	localparam int CONV_CYC = (CONV_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
	localparam int CNV_HIGH_NS = 200;
	localparam int CNV_HIGH_CYC = (CNV_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam logic [CNT_W-1:0] CNV_LAST = CNT_W'(CNV_HIGH_CYC - 1);
	// host shift clock divider and frame shape
	localparam int HALF_CYC = 4;
	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
	localparam logic [CNT_W-1:0] CFG_CHG = CNT_W'(HALF_CYC / 2);
	localparam logic [CNT_W-1:0] SETUP_LAST = 8'h03;
	localparam logic [CNT_W-1:0] CMOS_LAST_EDGE = 8'h31;
	localparam logic [CNT_W-1:0] LVDS_LAST_EDGE = 8'hc1;
	localparam logic [CNT_W-1:0] STREAM_EDGE = 8'hc0;
	// device reference-domain synchroniser bits
	localparam int SYNC_W = 5;
	localparam int SY_CNV = 0;
	localparam int SY_PD = 1;
	localparam int SY_CS = 2;
	localparam int SY_MODE = 3;
	localparam int SY_DONE = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST = 5'h04;
	typedef logic [REC_W-1:0] ssadc_rec_t;
endpackage

// [ssadc_link_if.sv]
// serial link between the converter and its host controller
`timescale 1ns/100ps
interface ssadc_link_if;
	logic shift_clock_in;
	logic cs_n;
	logic convert_start;
	logic power_down_in;
	logic lvds_mode;
	logic config_serial_in;
	logic diff_config_in;
	logic [ssadc_pkg::NUM_CH-1:0] result_lanes;
	logic diff_result_out;
	logic shift_clock_echo;
	logic diff_shift_clock_echo;
	logic cmos_oe;
	logic lvds_oe;
	logic busy;
	modport dev (
		input shift_clock_in, cs_n, convert_start, power_down_in, lvds_mode,
		input config_serial_in, diff_config_in,
		output result_lanes, diff_result_out, shift_clock_echo,
		output diff_shift_clock_echo, cmos_oe, lvds_oe, busy
	);
	modport host (
		output shift_clock_in, cs_n, convert_start, power_down_in, lvds_mode,
		output config_serial_in, diff_config_in,
		input result_lanes, diff_result_out, shift_clock_echo,
		input diff_shift_clock_echo, cmos_oe, lvds_oe, busy
	);
endinterface

// [ssadc_dev.sv]
// converter end: conversion control, power down and serial shifting
// Behaviour
// - all channels held at one instant
// - power down ignores new conversion starts
// - running conversion finishes before power down
// - two power-down rises without conversion reset all
// - mode pin high lvds, low cmos
// - convert rising edge holds and starts conversion
// - convert start not gated by chip select
// - busy high from start until conversion end
// - cmos lane n carries channel n
// - cmos lanes shift on shift clock rise
// - cmos config sampled on shift clock rise
// - host captures cmos data on rising edges
// - echo clock toggles each rise, half rate
// - echo forced low on a shift clock rise after busy falls
// - host sends 24-bit word on cmos input
// - host may hold config input high
// - chip select enables bus, gates clock
// - lvds mode leaves cmos pins undriven
// - lvds config taken on both edges
// - lvds data both edges, channel zero first
// - lvds echo is received clock copy
// - host idles lvds clock low
// - config word is eight 3-bit codes
`timescale 1ns/100ps
module ssadc_dev (
	// link pins
	ssadc_link_if.dev link,
	// reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// analog core samples, channel n in slice n
	input wire logic [ssadc_pkg::NUM_CH*ssadc_pkg::RES_W-1:0] i_chan_sample,
	// status
	output logic [ssadc_pkg::CFG_W-1:0] o_range_cfg,
	output logic o_powered_down,
	output logic o_conv_done
);
	import ssadc_pkg::*;

	logic [SYNC_W-1:0] sy1_q, sy2_q, sy3_q;
	logic busy_q, pd_seen_q, pdn_q, done_q, bfall_tog_q;
	logic cmos_oe_q, lvds_oe_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CFG_W-1:0] cfg_q, code_q;
	logic [RES_W-1:0] held_q [NUM_CH];
	logic [RES_W-1:0] res_q [NUM_CH];
	ssadc_rec_t rec [NUM_CH];
	// link-domain state
	logic first_q, echo_q, pos_q, hold_q, neg_q;
	logic rise_bit_q, fall_bit_q, cfg_done_q;
	logic [2:0] bf_q, bf_v_q;
	logic [NUM_CH-1:0] lane_q;
	ssadc_rec_t lane_sr_q [NUM_CH];
	ssadc_rec_t src [NUM_CH+1];
	ssadc_rec_t nxt [NUM_CH];
	logic [CFG_W-1:0] cfg_sr_q;
	logic [CFGCNT_W-1:0] cfg_cnt_q;

	wire logic [SYNC_W-1:0] sync_in = {cfg_done_q, link.lvds_mode,
		link.cs_n, link.power_down_in, link.convert_start};
	wire logic cnv_rise = sy2_q[SY_CNV] & ~sy3_q[SY_CNV];
	wire logic pd_rise = sy2_q[SY_PD] & ~sy3_q[SY_PD];
	wire logic done_rise = sy2_q[SY_DONE] & ~sy3_q[SY_DONE];
	wire logic pd_hi = sy2_q[SY_PD];
	wire logic cs_low = ~sy2_q[SY_CS];
	wire logic lvds = sy2_q[SY_MODE];
	wire logic conv_start = cnv_rise & ~busy_q & ~pd_hi;
	wire logic conv_end = busy_q & (cnt_q == CONV_LAST);
	wire logic glob_rst = pd_rise & pd_seen_q;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sy1_q <= SYNC_RST;
			sy2_q <= SYNC_RST;
			sy3_q <= SYNC_RST;
		end else begin
			sy1_q <= sync_in;
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q <= 1'h0;
			cnt_q <= '0;
			bfall_tog_q <= 1'h0;
		end else if (glob_rst) begin
			busy_q <= 1'h0;
			cnt_q <= '0;
		end else if (conv_start) begin
			busy_q <= 1'h1;
			cnt_q <= '0;
		end else if (conv_end) begin
			busy_q <= 1'h0;
			bfall_tog_q <= ~bfall_tog_q;
		end else if (busy_q) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// word latched, used from next start
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cfg_q <= CFG_RESET;
			code_q <= CFG_RESET;
		end else if (glob_rst) begin
			cfg_q <= CFG_RESET;
			code_q <= CFG_RESET;
		end else begin
			if (done_rise)
				cfg_q <= cfg_sr_q;
			if (conv_start)
				code_q <= cfg_q;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			pd_seen_q <= 1'h0;
			pdn_q <= 1'h0;
			done_q <= 1'h0;
		end else begin
			pdn_q <= pd_hi & ~busy_q;
			done_q <= conv_end & ~glob_rst;
			if (glob_rst)
				pd_seen_q <= 1'h0;
			else if (pd_rise)
				pd_seen_q <= 1'h1;
			else if (conv_start)
				pd_seen_q <= 1'h0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cmos_oe_q <= 1'h0;
			lvds_oe_q <= 1'h0;
		end else begin
			cmos_oe_q <= cs_low & ~lvds;
			lvds_oe_q <= cs_low & lvds;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int n = 0; n < NUM_CH; n++) begin
				held_q[n] <= '0;
				res_q[n] <= '0;
			end
		end else begin
			for (int n = 0; n < NUM_CH; n++) begin
				if (conv_start)
					held_q[n] <= i_chan_sample[n*RES_W +: RES_W];
				if (glob_rst)
					res_q[n] <= '0;
				else if (conv_end)
					res_q[n] <= (code_q[n*CODE_W +: CODE_W] == CODE_OFF) ?
						'0 : held_q[n];
			end
		end
	end

	// link logic is cleared while chip select is high
	// clock blocked outside the frame
	wire logic link_rst = i_rst | link.cs_n;
	wire logic [CFGCNT_W-1:0] cfg_step = lvds ? CFG_STEP_LVDS : CFG_STEP_CMOS;
	wire logic [CFGCNT_W-1:0] cnt_nxt = cfg_cnt_q + cfg_step;
	wire logic room = cfg_cnt_q < CFG_BITS;
	wire logic cmos_take = ~lvds & room;
	wire logic lvds_take = lvds & ~first_q & room;

	assign src[NUM_CH] = '0;
	for (genvar n = 0; n < NUM_CH; n++) begin : g_lane
		// code of channel n from its slice
		assign rec[n] = {res_q[n], code_q[n*CODE_W +: CODE_W],
			CH_ID_W'(n), REC_PAD};
		assign src[n] = first_q ? rec[n] : lane_sr_q[n];
		// lvds chains lanes, two bits a rise
		assign nxt[n] = lvds ?
			{src[n][REC_W-3:0], src[n+1][REC_W-1 -: 2]} :
			{src[n][REC_W-2:0], 1'h0};
	end

	always_ff @(posedge link.shift_clock_in or posedge link_rst) begin
		if (link_rst) begin
			for (int n = 0; n < NUM_CH; n++)
				lane_sr_q[n] <= '0;
			lane_q <= '0;
			first_q <= 1'h1;
			pos_q <= 1'h0;
			hold_q <= 1'h0;
		end else begin
			for (int n = 0; n < NUM_CH; n++) begin
				lane_sr_q[n] <= nxt[n];
				lane_q[n] <= src[n][REC_W-1];
			end
			first_q <= 1'h0;
			pos_q <= src[0][REC_W-1];
			hold_q <= src[0][REC_W-2];
		end
	end

	// echo clock, cleared after busy falls
	wire logic bf_edge = bf_v_q[2] & (bf_q[2] ^ bf_q[1]);
	always_ff @(posedge link.shift_clock_in or posedge link_rst) begin
		if (link_rst) begin
			bf_q <= 3'h0;
			bf_v_q <= 3'h0;
			echo_q <= 1'h0;
		end else begin
			bf_q <= {bf_q[1:0], bfall_tog_q};
			bf_v_q <= {bf_v_q[1:0], 1'h1};
			echo_q <= bf_edge ? 1'h0 : ~echo_q;
		end
	end

	always_ff @(posedge link.shift_clock_in or posedge link_rst) begin
		if (link_rst) begin
			cfg_sr_q <= '0;
			cfg_cnt_q <= '0;
			cfg_done_q <= 1'h0;
			rise_bit_q <= 1'h0;
		end else begin
			rise_bit_q <= link.diff_config_in;
			if (cmos_take)
				cfg_sr_q <= {cfg_sr_q[CFG_W-2:0], link.config_serial_in};
			else if (lvds_take)
				cfg_sr_q <= {cfg_sr_q[CFG_W-3:0], rise_bit_q, fall_bit_q};
			if (cmos_take | lvds_take)
				cfg_cnt_q <= cnt_nxt;
			if ((cmos_take | lvds_take) & (cnt_nxt == CFG_BITS))
				cfg_done_q <= 1'h1;
		end
	end

	// falling-edge half of the lvds lane
	always_ff @(negedge link.shift_clock_in or posedge link_rst) begin
		if (link_rst) begin
			neg_q <= 1'h0;
			fall_bit_q <= 1'h0;
		end else begin
			neg_q <= hold_q;
			fall_bit_q <= link.diff_config_in;
		end
	end

	assign link.result_lanes = lane_q;
	// clock level selects the rising or falling bit
	assign link.diff_result_out = link.shift_clock_in ? pos_q : neg_q;
	assign link.shift_clock_echo = echo_q;
	// forwarded copy of the shift clock
	assign link.diff_shift_clock_echo = link.shift_clock_in;
	assign link.cmos_oe = cmos_oe_q;
	assign link.lvds_oe = lvds_oe_q;
	assign link.busy = busy_q;
	assign o_range_cfg = cfg_q;
	assign o_powered_down = pdn_q;
	assign o_conv_done = done_q;
endmodule

// [ssadc_host.sv]
// host end: starts conversions, writes ranges and reads result records
`timescale 1ns/100ps
module ssadc_host (
	// link pins
	ssadc_link_if.host link,
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// user controls
	input wire logic i_lvds_sel,
	input wire logic i_power_down,
	input wire logic i_conv_req,
	input wire logic i_read_req,
	input wire logic [ssadc_pkg::CFG_W-1:0] i_cfg_word,
	// results
	output logic [ssadc_pkg::STREAM_W-1:0] o_records,
	output logic o_rec_valid,
	output logic o_idle,
	output logic o_busy
);
	import ssadc_pkg::*;

	typedef enum logic [5:0] {
		H_IDLE = 6'h01,
		H_CNV = 6'h02,
		H_BUSY = 6'h04,
		H_SETUP = 6'h08,
		H_SHIFT = 6'h10,
		H_HOLD = 6'h20
	} ssadc_hstate_t;

	ssadc_hstate_t state_q;
	logic [CNT_W-1:0] cnt_q, edge_q;
	logic sclk_q, cs_n_q, cnv_q, mode_q, pd_q, valid_q;
	logic [CFG_W-1:0] cfg_sh_q;
	logic [STREAM_W-1:0] buf_q;
	logic [NUM_CH+1:0] sy1_q, sy2_q;
	logic [STREAM_W-1:0] cmos_nxt;

	wire logic [NUM_CH+1:0] sync_in = {link.busy, link.result_lanes,
		link.diff_result_out};
	wire logic busy_s = sy2_q[NUM_CH+1];
	wire logic diff_s = sy2_q[0];
	wire logic tick = cnt_q == HALF_LAST;
	wire logic last_edge = edge_q == (mode_q ? LVDS_LAST_EDGE : CMOS_LAST_EDGE);
	// cmos before each rise, lvds before each edge
	wire logic cap = (state_q == H_SHIFT) & tick & (edge_q != 8'h00) &
		(mode_q ? (edge_q <= STREAM_EDGE) : ~sclk_q);
	// next bit after the edge that took it
	wire logic cfg_adv = (state_q == H_SHIFT) & (cnt_q == CFG_CHG) &
		(edge_q != 8'h00) & (mode_q | sclk_q);

	for (genvar n = 0; n < NUM_CH; n++) begin : g_cap
		assign cmos_nxt[STREAM_W-1-n*REC_W -: REC_W] =
			{buf_q[STREAM_W-2-n*REC_W -: REC_W-1], sy2_q[n+1]};
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sy1_q <= '0;
			sy2_q <= '0;
			mode_q <= 1'h0;
			pd_q <= 1'h0;
		end else begin
			sy1_q <= sync_in;
			sy2_q <= sy1_q;
			mode_q <= i_lvds_sel;
			pd_q <= i_power_down;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			buf_q <= '0;
		else if (cap)
			buf_q <= mode_q ? {buf_q[STREAM_W-2:0], diff_s} : cmos_nxt;
	end

	// word shifted msb first, ones behind it
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			cfg_sh_q <= CFG_RESET;
		else if ((state_q == H_IDLE) & ~i_conv_req & i_read_req & ~busy_s)
			cfg_sh_q <= i_cfg_word;
		else if (cfg_adv)
			cfg_sh_q <= {cfg_sh_q[CFG_W-2:0], 1'h1};
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= H_IDLE;
			cnt_q <= '0;
			edge_q <= '0;
			sclk_q <= 1'h0;
			cs_n_q <= 1'h1;
			cnv_q <= 1'h0;
			valid_q <= 1'h0;
		end else begin
			valid_q <= 1'h0;
			unique case (state_q)
				H_IDLE: begin
					cnt_q <= '0;
					if (i_conv_req) begin
						cnv_q <= 1'h1;
						state_q <= H_CNV;
					end else if (i_read_req & ~busy_s) begin
						cs_n_q <= 1'h0;
						state_q <= H_SETUP;
					end
				end
				H_CNV: begin
					cnt_q <= cnt_q + 8'h01;
					if (cnt_q == CNV_LAST) begin
						cnv_q <= 1'h0;
						state_q <= H_BUSY;
					end
				end
				H_BUSY: begin
					if (~busy_s)
						state_q <= H_IDLE;
				end
				H_SETUP: begin
					cnt_q <= cnt_q + 8'h01;
					edge_q <= '0;
					if (cnt_q == SETUP_LAST) begin
						cnt_q <= '0;
						state_q <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					cnt_q <= tick ? '0 : cnt_q + 8'h01;
					if (tick) begin
						sclk_q <= ~sclk_q;
						edge_q <= edge_q + 8'h01;
						if (last_edge)
							state_q <= H_HOLD;
					end
				end
				H_HOLD: begin
					// clock already low when select rises
					cnt_q <= tick ? '0 : cnt_q + 8'h01;
					if (tick) begin
						cs_n_q <= 1'h1;
						valid_q <= 1'h1;
						state_q <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign link.shift_clock_in = sclk_q;
	assign link.cs_n = cs_n_q;
	assign link.convert_start = cnv_q;
	assign link.power_down_in = pd_q;
	assign link.lvds_mode = mode_q;
	assign link.config_serial_in = cfg_sh_q[CFG_W-1];
	assign link.diff_config_in = cfg_sh_q[CFG_W-1];
	assign o_records = buf_q;
	assign o_rec_valid = valid_q;
	assign o_idle = state_q[0];
	assign o_busy = busy_s;
endmodule

// [ssadc_props.sv]
// checker for the signals of the converter link
`timescale 1ns/100ps
module ssadc_props (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// link signals
	input wire logic shift_clock_in,
	input wire logic cs_n,
	input wire logic convert_start,
	input wire logic power_down_in,
	input wire logic lvds_mode,
	input wire logic shift_clock_echo,
	input wire logic diff_shift_clock_echo,
	input wire logic cmos_oe,
	input wire logic lvds_oe,
	input wire logic busy
);
	logic [7:0] bcnt_q;
	logic [7:0] bcnt_d;
	// length of the current busy pulse
	assign bcnt_d = busy ? bcnt_q + 8'h01 : 8'h00;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			bcnt_q <= 8'h00;
		end else begin
			bcnt_q <= bcnt_d;
		end
	end
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_start;
		$rose(convert_start) && !busy && !power_down_in;
	endsequence
	sequence s_busy_end;
		$fell(busy);
	endsequence
	property p_busy_start;
		s_start |-> ##[1:6] busy;
	endproperty
	a_busy_start: assert property (p_busy_start)
		else $error("busy missing after convert start");
	property p_busy_len;
		s_busy_end |-> bcnt_q == 8'h78;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	property p_pd_block;
		power_down_in && $past(power_down_in, 6) && !busy |=> !busy;
	endproperty
	a_pd_block: assert property (p_pd_block)
		else $error("conversion started in power down");
	property p_cs_off;
		cs_n [*4] |-> !cmos_oe && !lvds_oe && !shift_clock_echo;
	endproperty
	a_cs_off: assert property (p_cs_off)
		else $error("bus driven while deselected");
	property p_lvds_quiet;
		lvds_mode |-> !cmos_oe;
	endproperty
	a_lvds_quiet: assert property (p_lvds_quiet)
		else $error("single-ended pins driven in lvds mode");
	property p_lvds_on;
		(lvds_mode && !cs_n) [*5] |-> lvds_oe;
	endproperty
	a_lvds_on: assert property (p_lvds_on)
		else $error("lvds outputs not enabled");
	property p_cmos_on;
		(!lvds_mode && !cs_n) [*5] |-> cmos_oe && !lvds_oe;
	endproperty
	a_cmos_on: assert property (p_cmos_on)
		else $error("cmos outputs not enabled");
	property p_echo_copy;
		lvds_oe |-> diff_shift_clock_echo == shift_clock_in;
	endproperty
	a_echo_copy: assert property (p_echo_copy)
		else $error("lvds echo differs from shift clock");
	property p_clk_idle;
		cs_n || $changed(cs_n) |-> !shift_clock_in;
	endproperty
	a_clk_idle: assert property (p_clk_idle)
		else $error("shift clock not idle low");
	property p_echo_toggle;
		$rose(shift_clock_in) && $past(shift_clock_echo) |-> !shift_clock_echo;
	endproperty
	a_echo_toggle: assert property (p_echo_toggle)
		else $error("echo clock did not fall");
endmodule

// [tb.sv]
// self-checking bench joining the host and converter ends
`timescale 1ns/100ps
module tb;
	import ssadc_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_lvds_sel = 1'b0;
	logic i_power_down = 1'b0;
	logic i_conv_req = 1'b0;
	logic i_read_req = 1'b0;
	logic [CFG_W-1:0] i_cfg_word = '0;
	logic [NUM_CH*RES_W-1:0] i_chan_sample = '0;
	logic [STREAM_W-1:0] o_records;
	logic o_rec_valid;
	logic o_idle;
	logic o_busy;
	logic [CFG_W-1:0] o_range_cfg;
	logic o_powered_down;
	logic o_conv_done;
	int failures = 0;
	int samples_checked = 0;
	ssadc_link_if link ();
	ssadc_host ssadc_host_i (.link(link), .i_ref_clk, .i_rst, .i_lvds_sel,
		.i_power_down, .i_conv_req, .i_read_req, .i_cfg_word, .o_records,
		.o_rec_valid, .o_idle, .o_busy);
	ssadc_dev ssadc_dev_i (.link(link), .i_ref_clk, .i_rst, .i_chan_sample,
		.o_range_cfg, .o_powered_down, .o_conv_done);
	ssadc_props ssadc_props_i (.i_ref_clk, .i_rst,
		.shift_clock_in(link.shift_clock_in), .cs_n(link.cs_n),
		.convert_start(link.convert_start),
		.power_down_in(link.power_down_in), .lvds_mode(link.lvds_mode),
		.shift_clock_echo(link.shift_clock_echo),
		.diff_shift_clock_echo(link.diff_shift_clock_echo),
		.cmos_oe(link.cmos_oe), .lvds_oe(link.lvds_oe), .busy(link.busy));
	always #12.5 i_ref_clk = ~i_ref_clk;
	task chk(input logic [191:0] seen, input logic [191:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task conclude();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(negedge i_ref_clk);
	endtask
	// channel 0 record sits at the top of the stream
	function automatic logic [191:0] exp_rec(input logic [127:0] s,
		input logic [23:0] w);
		logic [191:0] r;
		for (int n = 0; n < 8; n++) begin
			// a channel switched off reports an all-zero result
			r[(7-n)*24 +: 24] = {((w[3*n +: 3] == CODE_OFF) ? 16'h0 :
				s[16*n +: 16]), w[3*n +: 3], 3'(n), 2'h0};
		end
		return r;
	endfunction
	task conv(input logic pd_mid);
		int n;
		i_conv_req = 1'b1;
		cyc(1);
		i_conv_req = 1'b0;
		for (n = 0; n < 20 && link.busy !== 1'b1; n++) cyc(1);
		// the host's synchronised copy trails by two cycles
		cyc(3);
		chk(o_busy, 1'b1);
		n = 3;
		if (pd_mid) begin
			i_power_down = 1'b1;
			cyc(7);
			chk(o_powered_down, 1'b0);
			n = 10;
		end
		while (n < 300 && link.busy === 1'b1) begin
			cyc(1);
			n++;
		end
		chk(192'(n), 192'(CONV_CYC));
		chk(o_conv_done, 1'b1);
		cyc(6);
	endtask
	task rd(input logic [23:0] w, input logic [127:0] s,
		input logic [23:0] u);
		int n;
		i_cfg_word = w;
		i_read_req = 1'b1;
		cyc(1);
		i_read_req = 1'b0;
		for (n = 0; n < 2000 && o_rec_valid !== 1'b1; n++) cyc(1);
		chk(o_rec_valid, 1'b1);
		chk(o_idle, 1'b1);
		chk(o_records, exp_rec(s, u));
		cyc(10);
	endtask
	task t_cmos();
		i_chan_sample = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
		conv(1'b0);
		rd(24'h3f58d1, i_chan_sample, CFG_RESET);
		chk(o_range_cfg, 24'h3f58d1);
		i_chan_sample = 128'h8000_7fff_0001_fffe_a5a5_5a5a_c3c3_3c3c;
		conv(1'b0);
		rd(24'h3f58d1, i_chan_sample, 24'h3f58d1);
		$display("test cmos done");
	endtask
	task t_lvds();
		i_lvds_sel = 1'b1;
		cyc(10);
		i_chan_sample = ~i_chan_sample;
		conv(1'b0);
		rd(24'hfac745, i_chan_sample, 24'h3f58d1);
		chk(o_range_cfg, 24'hfac745);
		conv(1'b0);
		rd(24'hfac745, i_chan_sample, 24'hfac745);
		i_lvds_sel = 1'b0;
		cyc(10);
		$display("test lvds done");
	endtask
	task t_pd();
		conv(1'b1);
		chk(o_powered_down, 1'b1);
		i_conv_req = 1'b1;
		cyc(1);
		i_conv_req = 1'b0;
		cyc(20);
		chk(link.busy, 1'b0);
		i_power_down = 1'b0;
		cyc(10);
		i_power_down = 1'b1;
		cyc(10);
		chk(o_range_cfg, CFG_RESET);
		i_power_down = 1'b0;
		cyc(10);
		conv(1'b0);
		rd(24'h3f58d1, i_chan_sample, CFG_RESET);
		$display("test power down done");
	endtask
	initial begin
		cyc(20);
		i_rst = 1'b0;
		cyc(5);
		t_cmos();
		t_lvds();
		t_pd();
		conclude();
	end
	initial begin
		cyc(40000);
		failures++;
		conclude();
	end
endmodule
